// ### dtb_params.svh
`ifndef DTB_PARAMS_SVH
`define DTB_PARAMS_SVH
// Trace status codes
`define DTB_TRACE_CODE_STALL 3'h7
`define DTB_TRACE_CODE_JUMP_PC 3'h6
`define DTB_TRACE_CODE_JUMP_NOPC 3'h5
`define DTB_TRACE_CODE_EXCEPTION 3'h4
`define DTB_TRACE_CODE_SEQUENTIAL 3'h3
`define DTB_TRACE_CODE_STALL_TRACE 3'h2
`define DTB_TRACE_CODE_TRIGGER 3'h1
`define DTB_TRACE_CODE_DEBUG_RUN 3'h0
// Mode bit positions on the shared pins
`define DTB_MODE_ORIGIN 6
`define DTB_MODE_START 5
`define DTB_MODE_ACK 4
`define DTB_MODE_KIND 3
`define DTB_MODE_TRACE_HI 2
`define DTB_MODE_TRACE_LO 0
`define DTB_MODE_WIDTH 7
// Address bit carrying the PCI role strap
`define DTB_ROLE_ADDR_BIT 20
`define DTB_ROLE_SATELLITE 1'h1
`define DTB_ROLE_HOST 1'h0
// Block address field on the data bus
`define DTB_BLOCK_ADDR_HI 31
`define DTB_BLOCK_ADDR_LO 4
// Idle and reset levels of the monitor pins and data bus
`define DTB_MON_IDLE 1'h1
`define DTB_DATA_RESET 32'h0
// Trace sample clock divider and mode bits reset
`define DTB_DIV_RESET 4'h0
`define DTB_MODE_RESET 7'h00
`endif

// ### dtb_pkg.sv
package dtb_pkg;
  typedef enum logic [2:0] {
    DTB_EV_STALL,
    DTB_EV_JUMP_PC,
    DTB_EV_JUMP_NOPC,
    DTB_EV_EXCEPTION,
    DTB_EV_SEQUENTIAL,
    DTB_EV_STALL_TRACE,
    DTB_EV_TRIGGER,
    DTB_EV_DEBUG_RUN
  } dtb_event_t;
  typedef enum logic {
    DTB_PCI_HOST,
    DTB_PCI_SATELLITE
  } dtb_role_t;
endpackage

// ### dtb_sync_if.sv
`timescale 1ns/100ps
interface dtb_sync_if;
  logic tck_rise;
  logic mode_select;
  modport src (output tck_rise, output mode_select);
  modport dst (input tck_rise, input mode_select);
endinterface

// ### dtb_tck_sampler.sv
`timescale 1ns/100ps
`include "dtb_params.svh"
module dtb_tck_sampler (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Pins from the probe
  input wire logic boundary_test_clock,
  input wire logic trace_port_mode_select,
  // To the trace logic
  dtb_sync_if.src sync
);
  logic [1:0] tck_sync_r, tck_sync_nxt;
  logic [1:0] sel_sync_r, sel_sync_nxt;
  logic tck_last_r, tck_last_nxt;
  logic sel_r, sel_nxt;

  always_comb begin
    tck_sync_nxt = {tck_sync_r[0], boundary_test_clock};
    sel_sync_nxt = {sel_sync_r[0], trace_port_mode_select};
    tck_last_nxt = tck_sync_r[1];
    sel_nxt = sel_r;
    if (tck_sync_r[1] && !tck_last_r) begin
      sel_nxt = sel_sync_r[1];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tck_sync_r <= 2'h0;
      sel_sync_r <= 2'h0;
      tck_last_r <= 1'h0;
      sel_r <= 1'h0;
    end else begin
      tck_sync_r <= tck_sync_nxt;
      sel_sync_r <= sel_sync_nxt;
      tck_last_r <= tck_last_nxt;
      sel_r <= sel_nxt;
    end
  end

  assign sync.tck_rise = tck_sync_r[1] && !tck_last_r;
  assign sync.mode_select = sel_r;

  // select follows probe level at edge
  AST_SEL_ON_EDGE: assert property (@(posedge clk) disable iff (sys_rst)
    (tck_sync_r[1] && !tck_last_r) |=> sel_r == $past(sel_sync_r[1]))
    else $error("mode select not taken at test clock edge");
  AST_SEL_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    !(tck_sync_r[1] && !tck_last_r) |=> $stable(sel_r))
    else $error("mode select changed without test clock edge");
  COV_TCK_EDGE: cover property (@(posedge clk) sync.tck_rise);
endmodule

// ### dtb_debug_trace.sv
`timescale 1ns/100ps
`include "dtb_params.svh"
module dtb_debug_trace #(
  parameter int DIV_WIDTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Cold reset and straps
  input wire logic power_on_reset_n,
  input wire logic [31:0] external_address_bus,
  input wire logic [`DTB_MODE_WIDTH-1:0] mode_pins_in,
  input wire logic pci_boot_enable,
  // Probe pins
  input wire logic boundary_test_clock,
  input wire logic trace_port_mode_select,
  // Trace source
  input wire dtb_pkg::dtb_event_t trace_event,
  input wire logic [DIV_WIDTH-1:0] trace_div,
  // Bus transaction source
  input wire logic bus_start,
  input wire logic bus_ack,
  input wire logic bus_from_dma,
  input wire logic bus_is_fetch,
  input wire logic [31:0] bus_block_addr,
  // Trace and monitor pins
  output logic [2:0] pc_trace_status,
  output logic origin_cpu_not_dma_n,
  output logic bus_start_monitor_n,
  output logic bus_ack_monitor_n,
  output logic access_kind_n,
  output logic debug_pins_oe,
  output logic [31:0] external_data_bus,
  output logic trace_sample_clock,
  output logic trace_realtime_mode,
  // Captured configuration
  output logic [`DTB_MODE_WIDTH-1:0] mode_bits,
  output dtb_pkg::dtb_role_t pci_role_select,
  output logic pci_eeprom_load_req
);
  dtb_sync_if sync ();

  dtb_tck_sampler u_sampler (
    .clk(clk),
    .sys_rst(sys_rst),
    .boundary_test_clock(boundary_test_clock),
    .trace_port_mode_select(trace_port_mode_select),
    .sync(sync)
  );

  function automatic logic [2:0] trace_code(dtb_pkg::dtb_event_t ev);
    case (ev)
      dtb_pkg::DTB_EV_STALL: trace_code = `DTB_TRACE_CODE_STALL;
      dtb_pkg::DTB_EV_JUMP_PC: trace_code = `DTB_TRACE_CODE_JUMP_PC;
      dtb_pkg::DTB_EV_JUMP_NOPC: trace_code = `DTB_TRACE_CODE_JUMP_NOPC;
      dtb_pkg::DTB_EV_EXCEPTION: trace_code = `DTB_TRACE_CODE_EXCEPTION;
      dtb_pkg::DTB_EV_SEQUENTIAL: trace_code = `DTB_TRACE_CODE_SEQUENTIAL;
      dtb_pkg::DTB_EV_STALL_TRACE:
        trace_code = `DTB_TRACE_CODE_STALL_TRACE;
      dtb_pkg::DTB_EV_TRIGGER: trace_code = `DTB_TRACE_CODE_TRIGGER;
      default: trace_code = `DTB_TRACE_CODE_DEBUG_RUN;
    endcase
  endfunction

  // Strap synchronisers
  logic [1:0] por_sync_r, por_sync_nxt;
  logic [`DTB_MODE_WIDTH-1:0] mode_s1_r, mode_s2_r;
  logic [1:0] role_sync_r;
  logic in_reset;

  assign por_sync_nxt = {por_sync_r[0], power_on_reset_n};
  assign in_reset = !por_sync_r[1];

  // Captured state
  logic [`DTB_MODE_WIDTH-1:0] mode_r, mode_nxt;
  logic role_r, role_nxt;
  logic eeprom_r, eeprom_nxt;
  logic [2:0] pcst_r, pcst_nxt;
  logic origin_r, origin_nxt;
  logic start_r, start_nxt;
  logic ack_r, ack_nxt;
  logic kind_r, kind_nxt;
  logic oe_r, oe_nxt;
  logic [31:0] data_r, data_nxt;
  logic [DIV_WIDTH-1:0] div_cnt_r, div_cnt_nxt;
  logic tsc_r, tsc_nxt;

  always_comb begin
    mode_nxt = mode_r;
    role_nxt = role_r;
    eeprom_nxt = 1'h0;
    if (in_reset) begin
      mode_nxt = mode_s2_r;
      role_nxt = role_sync_r[1];
      eeprom_nxt = (role_sync_r[1] == `DTB_ROLE_SATELLITE) &&
                   pci_boot_enable;
    end else begin
      eeprom_nxt = eeprom_r;
    end
  end

  always_comb begin
    pcst_nxt = pcst_r;
    origin_nxt = `DTB_MON_IDLE;
    start_nxt = `DTB_MON_IDLE;
    ack_nxt = `DTB_MON_IDLE;
    kind_nxt = `DTB_MON_IDLE;
    data_nxt = data_r;
    oe_nxt = !in_reset;
    pcst_nxt = trace_code(trace_event);
    if (bus_start) begin
      start_nxt = 1'h0;
      data_nxt = `DTB_DATA_RESET;
      data_nxt[`DTB_BLOCK_ADDR_HI:`DTB_BLOCK_ADDR_LO] =
        bus_block_addr[`DTB_BLOCK_ADDR_HI:`DTB_BLOCK_ADDR_LO];
    end
    ack_nxt = !bus_ack;
    if (bus_start || bus_ack) begin
      origin_nxt = !bus_from_dma;
      kind_nxt = bus_is_fetch && !bus_from_dma;
    end
    if (in_reset) begin
      pcst_nxt = `DTB_TRACE_CODE_DEBUG_RUN;
      origin_nxt = `DTB_MON_IDLE;
      start_nxt = `DTB_MON_IDLE;
      ack_nxt = `DTB_MON_IDLE;
      kind_nxt = `DTB_MON_IDLE;
    end
  end

  always_comb begin
    div_cnt_nxt = div_cnt_r;
    tsc_nxt = tsc_r;
    if (!sync.mode_select || in_reset) begin
      div_cnt_nxt = DIV_WIDTH'(`DTB_DIV_RESET);
      tsc_nxt = 1'h0;
    end else if (div_cnt_r >= trace_div) begin
      div_cnt_nxt = DIV_WIDTH'(`DTB_DIV_RESET);
      tsc_nxt = !tsc_r;
    end else begin
      div_cnt_nxt = div_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      por_sync_r <= 2'h0;
      mode_s1_r <= `DTB_MODE_RESET;
      mode_s2_r <= `DTB_MODE_RESET;
      role_sync_r <= 2'h0;
      mode_r <= `DTB_MODE_RESET;
      role_r <= `DTB_ROLE_HOST;
      eeprom_r <= 1'h0;
      pcst_r <= `DTB_TRACE_CODE_DEBUG_RUN;
      origin_r <= `DTB_MON_IDLE;
      start_r <= `DTB_MON_IDLE;
      ack_r <= `DTB_MON_IDLE;
      kind_r <= `DTB_MON_IDLE;
      oe_r <= 1'h0;
      data_r <= `DTB_DATA_RESET;
      div_cnt_r <= DIV_WIDTH'(`DTB_DIV_RESET);
      tsc_r <= 1'h0;
    end else begin
      por_sync_r <= por_sync_nxt;
      mode_s1_r <= mode_pins_in;
      mode_s2_r <= mode_s1_r;
      role_sync_r <= {role_sync_r[0],
                      external_address_bus[`DTB_ROLE_ADDR_BIT]};
      mode_r <= mode_nxt;
      role_r <= role_nxt;
      eeprom_r <= eeprom_nxt;
      pcst_r <= pcst_nxt;
      origin_r <= origin_nxt;
      start_r <= start_nxt;
      ack_r <= ack_nxt;
      kind_r <= kind_nxt;
      oe_r <= oe_nxt;
      data_r <= data_nxt;
      div_cnt_r <= div_cnt_nxt;
      tsc_r <= tsc_nxt;
    end
  end

  assign pc_trace_status = pcst_r;
  assign origin_cpu_not_dma_n = origin_r;
  assign bus_start_monitor_n = start_r;
  assign bus_ack_monitor_n = ack_r;
  assign access_kind_n = kind_r;
  assign debug_pins_oe = oe_r;
  assign external_data_bus = data_r;
  assign trace_sample_clock = tsc_r;
  assign trace_realtime_mode = sync.mode_select;
  assign mode_bits = mode_r;
  assign pci_role_select = dtb_pkg::dtb_role_t'(role_r);
  assign pci_eeprom_load_req = eeprom_r;

  AST_STALL_CODE: assert property (@(posedge clk) disable iff (sys_rst)
    (!in_reset && trace_event == dtb_pkg::DTB_EV_STALL)
    |=> pc_trace_status == `DTB_TRACE_CODE_STALL)
    else $error("stall code wrong");
  AST_SEQ_CODE: assert property (@(posedge clk) disable iff (sys_rst)
    (!in_reset && trace_event == dtb_pkg::DTB_EV_SEQUENTIAL)
    |=> pc_trace_status == `DTB_TRACE_CODE_SEQUENTIAL)
    else $error("sequential code wrong");
  AST_ORIGIN_DMA: assert property (@(posedge clk) disable iff (sys_rst)
    (!in_reset && bus_ack && bus_from_dma) |=> !origin_cpu_not_dma_n)
    else $error("origin not low for dma");
  AST_START: assert property (@(posedge clk) disable iff (sys_rst)
    (!in_reset && bus_start) |=> !bus_start_monitor_n &&
    external_data_bus[`DTB_BLOCK_ADDR_HI:`DTB_BLOCK_ADDR_LO] ==
    $past(bus_block_addr[`DTB_BLOCK_ADDR_HI:`DTB_BLOCK_ADDR_LO]))
    else $error("start marker or address wrong");
  AST_ACK: assert property (@(posedge clk) disable iff (sys_rst)
    !in_reset |=> bus_ack_monitor_n == !$past(bus_ack))
    else $error("ack marker wrong");
  AST_KIND: assert property (@(posedge clk) disable iff (sys_rst)
    (!in_reset && bus_start && bus_is_fetch && !bus_from_dma)
    |=> access_kind_n)
    else $error("fetch kind wrong");
  AST_ROLE: assert property (@(posedge clk) disable iff (sys_rst)
    in_reset |=> role_r == $past(role_sync_r[1]))
    else $error("role not captured");
  AST_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    (!in_reset && !$past(in_reset)) |=> $stable(mode_r) && $stable(role_r))
    else $error("straps changed outside reset");
  COV_START: cover property (@(posedge clk) !bus_start_monitor_n);
  COV_SAT: cover property (@(posedge clk) pci_eeprom_load_req);
  COV_TSC: cover property (@(posedge clk) $rose(trace_sample_clock));
endmodule

// ### dtb_probe_model.sv
`timescale 1ns/100ps
module dtb_probe_model (
  // Frame request from the bench
  go,
  sel,
  // Probe pins
  boundary_test_clock,
  trace_port_mode_select
);
  input wire logic go;
  input wire logic sel;
  output logic boundary_test_clock;
  output logic trace_port_mode_select;
  initial begin
    boundary_test_clock = 1'b0;
    trace_port_mode_select = 1'b1;
  end
  // Test clock rests low between frames
  always @(posedge go) begin
    #13;
    trace_port_mode_select = sel;
    repeat (2) begin
      #200 boundary_test_clock = 1'b1;
      #200 boundary_test_clock = 1'b0;
    end
    // Released line floats to its pull-up
    trace_port_mode_select = 1'b1;
  end
endmodule

// ### debug_trace_and_boot_mode_test.sv
`timescale 1ns/100ps
module debug_trace_and_boot_mode_test;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic power_on_reset_n = 1'b0;
  logic [31:0] external_address_bus = 32'h0;
  logic [6:0] mode_pins_in = 7'h00;
  logic pci_boot_enable = 1'b0;
  logic boundary_test_clock, trace_port_mode_select;
  logic go = 1'b0;
  logic sel = 1'b0;
  dtb_pkg::dtb_event_t trace_event = dtb_pkg::DTB_EV_DEBUG_RUN;
  logic [3:0] trace_div = 4'hF;
  logic bus_start = 1'b0;
  logic bus_ack = 1'b0;
  logic bus_from_dma = 1'b0;
  logic bus_is_fetch = 1'b0;
  logic [31:0] bus_block_addr = 32'h0;
  logic [2:0] pc_trace_status;
  logic origin_cpu_not_dma_n, bus_start_monitor_n, bus_ack_monitor_n;
  logic access_kind_n, debug_pins_oe, trace_sample_clock;
  logic trace_realtime_mode, pci_eeprom_load_req;
  logic [31:0] external_data_bus;
  logic [6:0] mode_bits;
  dtb_pkg::dtb_role_t pci_role_select;
  int errors = 0;
  int cmp_count = 0;
  int n;
  logic e_s = 1'b0;
  logic e_a = 1'b0;
  logic e_v = 1'b0;
  logic e_o, e_k;
  logic [31:0] e_d;
  logic [2:0] e_c = 3'h7;
  logic [2:0] codes [8] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};

  always #25 clk = ~clk;

  dtb_debug_trace #(.DIV_WIDTH(4)) DUT (.clk, .sys_rst, .power_on_reset_n,
    .external_address_bus, .mode_pins_in, .pci_boot_enable,
    .boundary_test_clock, .trace_port_mode_select, .trace_event, .trace_div,
    .bus_start, .bus_ack, .bus_from_dma, .bus_is_fetch, .bus_block_addr,
    .pc_trace_status, .origin_cpu_not_dma_n, .bus_start_monitor_n,
    .bus_ack_monitor_n, .access_kind_n, .debug_pins_oe, .external_data_bus,
    .trace_sample_clock, .trace_realtime_mode, .mode_bits, .pci_role_select,
    .pci_eeprom_load_req);

  dtb_probe_model P (.go, .sel, .boundary_test_clock,
    .trace_port_mode_select);

  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task give_verdict;
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task cold(input logic r, input logic [6:0] m, input logic b);
    @(posedge clk);
    power_on_reset_n <= 1'b0;
    external_address_bus <= 32'(r) << 20;
    mode_pins_in <= m;
    pci_boot_enable <= b;
    bus_start <= 1'b1;
    trace_event <= dtb_pkg::DTB_EV_STALL;
    repeat (8) @(posedge clk);
    #1;
    check(32'({bus_start_monitor_n, pc_trace_status, debug_pins_oe}), 32'h10);
    @(posedge clk);
    power_on_reset_n <= 1'b1;
    bus_start <= 1'b0;
    trace_event <= dtb_pkg::DTB_EV_DEBUG_RUN;
    repeat (6) @(posedge clk);
    #1;
    check(32'(mode_bits), 32'(m));
    check(32'(pci_role_select), 32'(r));
    check(32'(pci_eeprom_load_req), 32'(r & b));
    if (r == 1'b0) begin
      check(32'(pci_eeprom_load_req), 32'h0);
    end
    check(32'(debug_pins_oe), 32'h1);
    @(posedge clk);
    mode_pins_in <= ~m;
    external_address_bus <= ~external_address_bus;
    repeat (6) @(posedge clk);
    #1;
    check(32'({mode_bits, pci_role_select}), 32'({m, r}));
  endtask

  // Checks the previous call's answer while driving the next request
  task bus_op(input logic [3:0] f, input logic [31:0] ad,
              input logic [2:0] ev);
    @(posedge clk);
    {bus_is_fetch, bus_from_dma, bus_ack, bus_start} <= f;
    bus_block_addr <= ad;
    trace_event <= dtb_pkg::dtb_event_t'(ev);
    #1;
    check(32'(bus_start_monitor_n), 32'(!e_s));
    check(32'(bus_ack_monitor_n), 32'(!e_a));
    if (e_s | e_a) begin
      check(32'(origin_cpu_not_dma_n), 32'(e_o));
      check(32'(access_kind_n), 32'(e_k));
    end
    if (e_v) begin
      check(external_data_bus, e_d);
    end
    check(32'(pc_trace_status), 32'(codes[e_c]));
    e_s = f[0];
    e_a = f[1];
    e_o = !f[2];
    e_k = f[3] & !f[2];
    if (f[0]) begin
      e_v = 1'b1;
      e_d = {ad[31:4], 4'h0};
    end
    e_c = ev;
  endtask

  task frame(input logic s);
    @(posedge clk);
    sel <= s;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (40) @(posedge clk);
    #1;
  endtask

  task period(output int k);
    logic o;
    o = trace_sample_clock;
    k = 0;
    while (trace_sample_clock === o && k < 40) begin
      @(posedge clk);
      #1;
      k++;
    end
  endtask

  initial begin
    #300000;
    errors++;
    give_verdict;
  end

  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    cold(1'b1, 7'h55, 1'b0);
    cold(1'b0, 7'h2A, 1'b1);
    cold(1'b1, 7'h7F, 1'b1);
    for (int i = 0; i < 16; i++) begin
      bus_op({i[3:1], ~i[1] | i[0]}, {i[3:0], 28'hABCDEF5}, i[2:0]);
    end
    bus_op(4'h0, 32'h0, 3'h7);
    bus_op(4'h0, 32'h0, 3'h7);
    frame(1'b1);
    check(32'(trace_realtime_mode), 32'h1);
    period(n);
    period(n);
    check(n, 32'h10);
    @(posedge clk);
    trace_div <= 4'h3;
    #1;
    period(n);
    period(n);
    check(n, 32'h4);
    frame(1'b0);
    check(32'(trace_realtime_mode), 32'h0);
    give_verdict;
  end
endmodule
